// [hw/bfp_sequencer.sv]
// Per-channel cycle-by-cycle fault protection for a two-phase buck controller.
// Comparator results arrive as synchronous levels; gate pins are three-state.
`timescale 1ns/1ps

module bfp_channel
	import bfp_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic reset, // Synchronous, active high
	input wire logic cycle_start, // Start of this channel's switching cycle
	input wire logic [8:0] duty_cyc, // Requested on-time in clocks
	input wire logic ocp_below, // Switch node below overcurrent_threshold_level
	input wire logic uvp_low, // feedback_input at or below 82% of reference
	input wire logic ovp_high, // feedback_input at or above 116% of reference
	input wire logic en_below_1v, // Soft-start/enable pin below 1V
	input wire logic ss_done_in, // Soft-start ramp reached about 3.2V
	output logic hs_drv, // high_side_gate_drive level
	output logic ls_drv, // Low-side gate drive level
	output logic gate_oe_n, // Gate drivers enabled, active low
	output logic ss_dis, // Soft-start discharge switch on
	output logic oc_latched, // Latched off by overcurrent
	output logic ov_latched // Latched off by overvoltage
);
	bfp_state_t state_r, state_nxt;
	logic [8:0] on_cnt_r;
	logic hs_r, ls_r, oe_n_r, dis_r, ocl_r, ovl_r;
	logic oc_seen_r, ov_seen_r, uv_seen_r;
	logic [5:0] oc_cnt_r, ov_cnt_r;
	logic [3:0] uv_cnt_r;
	logic [10:0] dis_cnt_r;
	logic hiccup_r;

	wire active = (state_r == BFP_SOFTSTART) || (state_r == BFP_RUN);
	// Stays active after this edge; no fresh pulse on a trip edge
	wire active_nxt = (state_nxt == BFP_SOFTSTART) || (state_nxt == BFP_RUN);
	wire ov_armed = (state_r == BFP_RUN);
	wire oc_now = hs_r && ocp_below && active;
	wire ov_now = ov_armed && ovp_high;
	wire min_met = on_cnt_r + 9'h001 >= MIN_ON_CYC;
	wire [8:0] on_target = (duty_cyc < MIN_ON_CYC) ? MIN_ON_CYC :
		((duty_cyc > MAX_ON_CYC) ? MAX_ON_CYC : duty_cyc);
	wire hs_end = oc_now || (min_met && on_cnt_r + 9'h001 >= on_target);
	wire oc_cycle = oc_seen_r || oc_now;
	wire ov_cycle = ov_seen_r || ov_now;
	wire [5:0] oc_cnt_nxt = oc_cycle ? oc_cnt_r + 6'h01 : 6'h00;
	wire [5:0] ov_cnt_nxt = ov_cycle ? ov_cnt_r + 6'h01 : 6'h00;
	wire [3:0] uv_cnt_nxt = (uv_seen_r || uvp_low) ? uv_cnt_r + 4'h1 : 4'h0;
	wire oc_trip = cycle_start && active && (oc_cnt_nxt == OC_LATCH_COUNT);
	wire ov_trip = cycle_start && ov_armed && (ov_cnt_nxt == OV_LATCH_COUNT);
	wire uv_trip = cycle_start && active && (uv_cnt_nxt == UV_HICCUP_COUNT);

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			BFP_OFF:
				if (!en_below_1v && !hiccup_r)
					state_nxt = BFP_SOFTSTART;
			BFP_SOFTSTART, BFP_RUN:
			begin
				if (en_below_1v)
					state_nxt = BFP_OFF;
				else if (oc_trip || ov_trip)
					state_nxt = BFP_LATCHED;
				else if (uv_trip)
					state_nxt = BFP_OFF;
				else if (state_r == BFP_SOFTSTART && ss_done_in)
					state_nxt = BFP_RUN;
			end
			BFP_LATCHED:
				if (en_below_1v)
					state_nxt = BFP_OFF;
			default:
				state_nxt = BFP_OFF;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			state_r <= BFP_OFF;
		else
			state_r <= state_nxt;
	end

	// Hiccup: discharge soft-start cap for a fixed time, then release
	always_ff @(posedge clk)
	begin
		if (reset || en_below_1v)
		begin
			hiccup_r <= 1'b0;
			dis_cnt_r <= '0;
		end
		else if (uv_trip && state_nxt == BFP_OFF)
		begin
			hiccup_r <= 1'b1;
			dis_cnt_r <= SS_DISCHARGE_CYC;
		end
		else if (hiccup_r)
		begin
			dis_cnt_r <= dis_cnt_r - 11'h001;
			if (dis_cnt_r == 11'h001)
				hiccup_r <= 1'b0;
		end
	end

	// Per-cycle fault counters, evaluated at each cycle boundary
	always_ff @(posedge clk)
	begin
		if (reset || !active)
		begin
			oc_cnt_r <= '0;
			ov_cnt_r <= '0;
			uv_cnt_r <= '0;
			oc_seen_r <= 1'b0;
			ov_seen_r <= 1'b0;
			uv_seen_r <= 1'b0;
		end
		else if (cycle_start)
		begin
			oc_cnt_r <= oc_cnt_nxt;
			ov_cnt_r <= ov_cnt_nxt;
			uv_cnt_r <= uv_cnt_nxt;
			oc_seen_r <= 1'b0;
			ov_seen_r <= 1'b0;
			uv_seen_r <= 1'b0;
		end
		else
		begin
			oc_seen_r <= oc_cycle;
			ov_seen_r <= ov_cycle;
			uv_seen_r <= uv_seen_r || uvp_low;
		end
	end

	// High-side pulse timing
	always_ff @(posedge clk)
	begin
		if (reset || !active)
		begin
			hs_r <= 1'b0;
			on_cnt_r <= '0;
		end
		else if (cycle_start && !ov_now && active_nxt)
		begin
			hs_r <= 1'b1;
			on_cnt_r <= '0;
		end
		else if (hs_r)
		begin
			on_cnt_r <= on_cnt_r + 9'h001;
			if (hs_end || ov_now)
				hs_r <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ls_r <= 1'b0;
			oe_n_r <= 1'b1;
			dis_r <= 1'b1;
			ocl_r <= 1'b0;
			ovl_r <= 1'b0;
		end
		else
		begin
			ls_r <= active && (ov_now || (!hs_r && !cycle_start));
			oe_n_r <= (state_nxt != BFP_SOFTSTART && state_nxt != BFP_RUN);
			dis_r <= (hiccup_r && dis_cnt_r != 11'h001) || (uv_trip && state_nxt == BFP_OFF);
			if (state_nxt == BFP_LATCHED && state_r != BFP_LATCHED)
			begin
				ocl_r <= oc_trip;
				ovl_r <= ov_trip && !oc_trip;
			end
			else if (state_nxt != BFP_LATCHED)
			begin
				ocl_r <= 1'b0;
				ovl_r <= 1'b0;
			end
		end
	end

	assign hs_drv = hs_r;
	assign ls_drv = ls_r;
	assign gate_oe_n = oe_n_r;
	assign ss_dis = dis_r;
	assign oc_latched = ocl_r;
	assign ov_latched = ovl_r;

	a_latch_gates_off: assert property (@(posedge clk) disable iff (reset)
		state_r == BFP_LATCHED |-> gate_oe_n && !hs_drv)
		else $error("latched channel gates not three-stated");
	a_oc_ends_pulse: assert property (@(posedge clk) disable iff (reset)
		oc_now |=> !hs_drv)
		else $error("overcurrent did not end high pulse");
	a_ov_unarmed_ss: assert property (@(posedge clk) disable iff (reset)
		state_r == BFP_SOFTSTART |-> !ov_now)
		else $error("overvoltage armed during soft-start");
	a_ov_holds_low: assert property (@(posedge clk) disable iff (reset)
		ov_now && !en_below_1v && !ov_trip |=> ls_drv)
		else $error("low gate not held on overvoltage");
	a_ov_no_discharge: assert property (@(posedge clk) disable iff (reset)
		ov_trip && !en_below_1v |=> !ss_dis)
		else $error("soft-start discharged on overvoltage latch");
	a_latch_stays: assert property (@(posedge clk) disable iff (reset)
		state_r == BFP_LATCHED && !en_below_1v |=> state_r == BFP_LATCHED)
		else $error("latch released without enable low");
	a_oc_count_clear: assert property (@(posedge clk) disable iff (reset)
		cycle_start && active && !oc_cycle |=> oc_cnt_r == 6'h00)
		else $error("overcurrent count not cleared");
	a_min_on_time: assert property (@(posedge clk) disable iff (reset)
		$fell(hs_drv) && !$past(oc_now) && !$past(ov_now) && $past(active)
		|-> $past(on_cnt_r) + 9'h001 >= MIN_ON_CYC)
		else $error("high pulse shorter than minimum");
	a_uv_hiccup: assert property (@(posedge clk) disable iff (reset)
		uv_trip && !oc_trip && !ov_trip && !en_below_1v |=> ss_dis)
		else $error("undervoltage did not start hiccup");
	c_oc_latch: cover property (@(posedge clk) disable iff (reset) oc_trip);
	c_ov_latch: cover property (@(posedge clk) disable iff (reset) ov_trip);
	c_hiccup: cover property (@(posedge clk) disable iff (reset) uv_trip);
endmodule

module bfp_sequencer
	import bfp_pkg::*;
(
	input wire logic clk, // System clock, 100 MHz
	input wire logic reset, // Synchronous, active high
	input wire logic [1:0][8:0] duty_cyc, // On-time request per channel
	input wire logic [1:0] ocp_below, // Switch node below threshold
	input wire logic [1:0] uvp_low, // Undervoltage comparator
	input wire logic [1:0] ovp_high, // Overvoltage comparator
	input wire logic [1:0] en_below_1v, // Enable pin below 1V
	input wire logic [1:0] ss_done_in, // Soft-start ramp complete
	output logic [1:0] hs_gate_o, // High gate output value
	output logic [1:0] hs_gate_oe_n, // High gate enable, active low
	output logic [1:0] ls_gate_o, // Low gate output value
	output logic [1:0] ls_gate_oe_n, // Low gate enable, active low
	output logic [1:0] ss_discharge, // Soft-start discharge switch
	output logic [1:0] oc_latched, // Overcurrent latch-off
	output logic [1:0] ov_latched // Overvoltage latch-off
);
	logic [8:0] phase_r;
	logic [1:0] start_r;
	logic [1:0] oe_n;

	always_ff @(posedge clk)
	begin
		if (reset)
			phase_r <= '0;
		else if (phase_r == SW_PERIOD_CYC - 9'h001)
			phase_r <= '0;
		else
			phase_r <= phase_r + 9'h001;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			start_r <= '0;
		else
			start_r <= {phase_r == HALF_PERIOD_CYC, phase_r == 9'h000};
	end

	a_antiphase: assert property (@(posedge clk) disable iff (reset)
		start_r[0] |-> ##(HALF_PERIOD_CYC) start_r[1])
		else $error("channels not in antiphase");
	c_both_run: cover property (@(posedge clk) disable iff (reset) &(~oe_n));

	for (genvar ch = 0; ch < 2; ch++)
	begin : g_ch
		bfp_channel u_ch (
			.clk(clk),
			.reset(reset),
			.cycle_start(start_r[ch]),
			.duty_cyc(duty_cyc[ch]),
			.ocp_below(ocp_below[ch]),
			.uvp_low(uvp_low[ch]),
			.ovp_high(ovp_high[ch]),
			.en_below_1v(en_below_1v[ch]),
			.ss_done_in(ss_done_in[ch]),
			.hs_drv(hs_gate_o[ch]),
			.ls_drv(ls_gate_o[ch]),
			.gate_oe_n(oe_n[ch]),
			.ss_dis(ss_discharge[ch]),
			.oc_latched(oc_latched[ch]),
			.ov_latched(ov_latched[ch])
		);
	end

	assign hs_gate_oe_n = oe_n;
	assign ls_gate_oe_n = oe_n;
endmodule

// [shared/bfp_pkg.sv]
// Constants for the dual-channel buck fault protection sequencer.
// Assumes one 100 MHz clock and comparator inputs already synchronous to it.
package bfp_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SW_PERIOD_NS = 3330;
	localparam logic [8:0] SW_PERIOD_CYC = 9'(SW_PERIOD_NS / CLK_PERIOD_NS);
	localparam logic [8:0] HALF_PERIOD_CYC = 9'(SW_PERIOD_NS / CLK_PERIOD_NS / 2);
	localparam int MIN_ON_NS = 100;
	localparam logic [8:0] MIN_ON_CYC = 9'((MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [8:0] MAX_ON_CYC = 9'(SW_PERIOD_NS / CLK_PERIOD_NS - 20);
	localparam int SS_DISCHARGE_NS = 10000;
	localparam logic [10:0] SS_DISCHARGE_CYC = 11'(SS_DISCHARGE_NS / CLK_PERIOD_NS);
	localparam logic [5:0] OC_LATCH_COUNT = 6'h20;
	localparam logic [5:0] OV_LATCH_COUNT = 6'h20;
	localparam logic [3:0] UV_HICCUP_COUNT = 4'h8;
	typedef enum logic [1:0] {BFP_OFF, BFP_SOFTSTART, BFP_RUN, BFP_LATCHED} bfp_state_t;
endpackage

// [bench/bfp_stage.sv]
// Behavioural power stage, sense comparators and soft-start ramps for both channels.
// Assumes the bench commands each fault condition; the ramp restarts on discharge.
`timescale 1ns/1ps
module bfp_stage
#(
	parameter int RAMP_CYC = 600
)
(
	input wire logic clk, // System clock
	input wire logic [1:0] hs_gate_o, // High gate level
	input wire logic [1:0] hs_gate_oe_n, // High gate enable, active low
	input wire logic [1:0] ss_discharge, // Discharge switch on
	input wire logic [1:0] en_below_1v, // Enable pin pulled low
	input wire logic [1:0] oc_cmd, // Output shorted
	input wire logic [1:0] uv_cmd, // Output sagging
	input wire logic [1:0] ov_cmd, // Output too high
	output logic [1:0] ocp_below, // Switch node below threshold
	output logic [1:0] uvp_low, // Undervoltage comparator
	output logic [1:0] ovp_high, // Overvoltage comparator
	output logic [1:0] ss_done_in // Ramp complete
);
	int ramp [2] = '{0, 0};
	// Node only sags while the high side conducts
	assign ocp_below = oc_cmd & hs_gate_o & ~hs_gate_oe_n;
	assign uvp_low = uv_cmd;
	assign ovp_high = ov_cmd;
	assign ss_done_in = {ramp[1] == RAMP_CYC, ramp[0] == RAMP_CYC};
	always @(posedge clk)
	begin
		for (int i = 0; i < 2; i++)
		begin
			if (ss_discharge[i] || en_below_1v[i])
				ramp[i] <= 0;
			else if (ramp[i] < RAMP_CYC)
				ramp[i] <= ramp[i] + 1;
		end
	end
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the two-channel fault protection sequencer.
// Assumes the behavioural power stage closes the loop on the gate pins.
`timescale 1ns/1ps
module tb_top;
	import bfp_pkg::*;
	logic clk;
	logic reset;
	logic [1:0][8:0] duty_cyc;
	logic [1:0] en_below_1v, oc_cmd, uv_cmd, ov_cmd, ocp_below, uvp_low, ovp_high, ss_done_in;
	logic [1:0] hs_gate_o, hs_gate_oe_n, ls_gate_o, ls_gate_oe_n;
	logic [1:0] ss_discharge, oc_latched, ov_latched;
	int fail_count = 0;
	int samples_checked = 0;
	int n;
	bfp_sequencer bfp_sequencer_inst (.clk(clk), .reset(reset), .duty_cyc(duty_cyc),
		.ocp_below(ocp_below), .uvp_low(uvp_low), .ovp_high(ovp_high),
		.en_below_1v(en_below_1v), .ss_done_in(ss_done_in), .hs_gate_o(hs_gate_o),
		.hs_gate_oe_n(hs_gate_oe_n), .ls_gate_o(ls_gate_o), .ls_gate_oe_n(ls_gate_oe_n),
		.ss_discharge(ss_discharge), .oc_latched(oc_latched), .ov_latched(ov_latched));
	bfp_stage bfp_stage_inst (.clk(clk), .hs_gate_o(hs_gate_o), .hs_gate_oe_n(hs_gate_oe_n),
		.ss_discharge(ss_discharge), .en_below_1v(en_below_1v), .oc_cmd(oc_cmd),
		.uv_cmd(uv_cmd), .ov_cmd(ov_cmd), .ocp_below(ocp_below), .uvp_low(uvp_low),
		.ovp_high(ovp_high), .ss_done_in(ss_done_in));
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	task automatic print_verdict();
		if (fail_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input bit ok, input string msg);
		samples_checked++;
		if (!ok)
		begin
			fail_count++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask
	task automatic step(inout int cnt, input int lim);
		@(negedge clk);
		cnt++;
		if (cnt > lim)
		begin
			check(1'h0, "wait timed out");
			print_verdict();
		end
	endtask
	// Enable pin pulled low briefly, so the channel runs a fresh soft-start
	task automatic restart(input int ch);
		en_below_1v[ch] = 1'h1;
		repeat (2) @(negedge clk);
		check(hs_gate_oe_n[ch] === 1'h1, "enable low not off");
		en_below_1v[ch] = 1'h0;
	endtask
	// Clocks until the high gate of a channel next rises
	task automatic rise(input int ch, output int cnt);
		logic prev;
		cnt = 0;
		do
		begin
			prev = hs_gate_o[ch];
			step(cnt, 2000);
		end
		while (!(prev === 1'h0 && hs_gate_o[ch] === 1'h1));
	endtask
	task automatic t_phase();
		int w;
		rise(0, n);
		rise(1, n);
		check(9'(n) === HALF_PERIOD_CYC, "phase offset");
		rise(0, n);
		w = 0;
		while (hs_gate_o[0] === 1'h1)
			step(w, 400);
		check(9'(w) === MIN_ON_CYC, "min on-time");
	endtask
	// 31 events, one clean cycle, then 32 events, all from soft-start on
	task automatic t_oc();
		restart(0);
		oc_cmd[0] = 1'h1;
		for (int i = 0; i < 64; i++)
		begin
			oc_cmd[0] = (i != 31);
			rise(0, n);
			check(oc_latched[0] === 1'h0, "early latch");
			repeat (3) @(negedge clk);
			if (i != 31)
				check(hs_gate_o[0] === 1'h0, "pulse not cut");
			repeat (17) @(negedge clk);
		end
		n = 0;
		while (oc_latched[0] !== 1'h1)
			step(n, 400);
		check(hs_gate_oe_n[0] === 1'h1 && ls_gate_oe_n[0] === 1'h1, "gates driven");
		check(oc_latched[1] === 1'h0 && hs_gate_oe_n[1] === 1'h0, "ch1 disturbed");
		oc_cmd[0] = 1'h0;
		repeat (1000) @(negedge clk);
		check(oc_latched[0] === 1'h1, "latch lost");
		en_below_1v[0] = 1'h1;
		n = 0;
		while (oc_latched[0] !== 1'h0)
			step(n, 20);
		en_below_1v[0] = 1'h0;
		rise(0, n);
	endtask
	task automatic t_uv();
		int w;
		uv_cmd[1] = 1'h1;
		for (int i = 0; i < 7; i++)
		begin
			rise(1, n);
			check(ss_discharge[1] === 1'h0, "early hiccup");
		end
		n = 0;
		while (ss_discharge[1] !== 1'h1)
			step(n, 400);
		uv_cmd[1] = 1'h0;
		w = 0;
		while (ss_discharge[1] === 1'h1)
			step(w, 1200);
		check(11'(w) === SS_DISCHARGE_CYC, "discharge time");
		rise(1, n);
	endtask
	// Condition raised in soft-start, where switching must go on
	task automatic t_ov();
		bit bad;
		restart(0);
		ov_cmd[0] = 1'h1;
		rise(0, n);
		n = 0;
		while (ss_done_in[0] !== 1'h1)
			step(n, 1000);
		repeat (3) @(negedge clk);
		bad = 1'h0;
		for (int w = 0; w < 10300; w++)
		begin
			@(negedge clk);
			bad |= (hs_gate_o[0] !== 1'h0) || (ls_gate_o[0] !== 1'h1) || (ov_latched[0] !== 1'h0);
		end
		check(!bad, "low gate not held");
		n = 0;
		while (ov_latched[0] !== 1'h1)
			step(n, 800);
		check(hs_gate_oe_n[0] === 1'h1 && ls_gate_oe_n[0] === 1'h1, "ov gates");
		check(ss_discharge[0] === 1'h0, "cap discharged");
		ov_cmd[0] = 1'h0;
		en_below_1v[0] = 1'h1;
		n = 0;
		while (ov_latched[0] !== 1'h0)
			step(n, 20);
		en_below_1v[0] = 1'h0;
	endtask
	initial
	begin
		reset = 1'h1;
		duty_cyc[0] = 9'h002;
		duty_cyc[1] = 9'h040;
		en_below_1v = 2'h0;
		oc_cmd = 2'h0;
		uv_cmd = 2'h0;
		ov_cmd = 2'h0;
		repeat (16) @(negedge clk);
		reset = 1'h0;
		t_phase();
		t_oc();
		t_uv();
		t_ov();
		print_verdict();
	end
endmodule
